/* File: breaker_defs.svh */
// offsets, field layouts, reset values and timing counts of the breaker supervision monitor
`ifndef BREAKER_DEFS_SVH
`define BREAKER_DEFS_SVH
// register byte offsets
`define ADR_CTRL    8'h00
`define ADR_CLASS   8'h04
`define ADR_A_CFG   8'h08
`define ADR_B_CFG   8'h0c
`define ADR_QUAL    8'h10
`define ADR_STATUS  8'h14
`define ADR_MASK    8'h18
`define ADR_STATE   8'h1c
// writable field masks
`define CTRL_MASK   32'h0000_0007
`define CLASS_MASK  32'h0000_0077
`define A_CFG_MASK  32'h03ff_03ff
`define B_CFG_MASK  32'h01ff_000f
`define QUAL_MASK   32'h0000_3f3f
`define EVT_MASK    32'h0000_0007
// reset values
`define CTRL_RST    32'h0000_0001
`define CLASS_RST   32'h0000_0011
`define A_CFG_RST   32'h001e_001e
`define B_CFG_RST   32'h00c8_0005
`define QUAL_RST    32'h0000_0000
// field positions
`define CTRL_B_ON   0
`define CTRL_A_SELF 1
`define CTRL_B_SELF 2
`define CTRL_ACK    3
// qualifier codes
`define QUAL_ALWAYS 6'h00
`define QUAL_LOCK   6'h01
`define QUAL_FLAG0  6'h02
// timing
`define CLK_HZ      10000000
`define TICK_MS     10
`define TICKS_PER_S 100
`define CLOSED_S    5
`define MAX_ATTEMPT 4'ha
`endif

/* File: breaker_pkg.sv */
// types shared by the breaker supervision monitor
package breaker_pkg;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;
    typedef enum logic [2:0] {
        CLASS_A = 3'h0, CLASS_B = 3'h1, CLASS_C = 3'h2, CLASS_D = 3'h3,
        CLASS_E = 3'h4, CLASS_F = 3'h5, CLASS_CONTROL = 3'h6
    } alarm_class_e;
    typedef enum logic [1:0] {
        OPEN_IDLE = 2'b00,
        OPEN_RUN  = 2'b01,
        OPEN_FAIL = 2'b10
    } open_state_e;
endpackage

/* File: breaker_supervision_monitor.sv */
// supervision of breaker a unload and breaker b close/open with wishbone registers
// What this block does
// [R01] open breaker a when power below trip level
// [R02] power stays high past delay: open, alarm
// [R03] each alarm carries a selectable alarm class
// [R04] self acknowledge clears alarm when fault gone
// [R05] latched alarm cleared by manual or external acknowledge
// [R06] qualifier always evaluates fault continuously
// [R07] qualifier lock evaluates only while lock inactive
// [R08] qualifier flag evaluates only while flag true
// [R09] breaker b supervision off suppresses both alarms
// [R10] count closing attempts, limit one to ten; the limit field takes 0 to 15 and the counter stops at ten
// [R11] attempt limit reached while open: close failure
// [R12] clear attempt counter after five seconds closed
// [R13] feedback de-energized closed, energized open
// [R14] open timer expires without feedback: open failure
// [R15] open failure shows message and command variable
// [R16] open failure uses breaker b alarm class
// [R17] timers run on tick, restart when removed
`timescale 1ns/1ps
`include "breaker_defs.svh"
module breaker_supervision_monitor #(
    parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // register bus
    input  wire breaker_pkg::wb_req_s   wb_i,
    output breaker_pkg::wb_rsp_s        wb_o,
    // system a power and unload sequence
    input  wire logic [9:0]             power_pct_i,
    input  wire logic                   a_unload_i,
    output logic                        breaker_a_open_o,
    // breaker b close and open sequence
    input  wire logic                   close_cmd_i,
    input  wire logic                   open_seq_i,
    input  wire logic                   breaker_b_feedback_i,
    output logic                        breaker_b_close_relay_o,
    // qualifiers and acknowledge
    input  wire logic                   lock_mon_i,
    input  wire logic [31:0]            logic_flag_n_i,
    input  wire logic                   ext_ack_i,
    // alarms, command variables and classes
    output logic                        a_unload_mismatch_msg_o,
    output logic                        b_close_failure_msg_o,
    output logic                        b_open_failure_msg_o,
    output breaker_pkg::alarm_class_e   a_class_o,
    output breaker_pkg::alarm_class_e   b_class_o,
    output logic                        irq_o
);
    import breaker_pkg::*;

    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
    localparam logic [9:0]  CLOSED_TICKS = 10'(`CLOSED_S * `TICKS_PER_S);

    // register file and state
    logic [31:0] ctrl_reg, class_reg, acfg_reg, bcfg_reg, qual_reg;
    logic [2:0]  status_reg, mask_reg, alarm_reg, cond_d_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic [16:0] tick_cnt_reg;
    logic        tick_reg;
    logic [1:0]  fb_sync_reg, ack_sync_reg;
    logic [16:0] a_tmr_reg;
    logic [3:0]  att_cnt_reg;
    logic        close_d_reg;
    logic [9:0]  closed_tmr_reg;
    logic [8:0]  open_tmr_reg;
    open_state_e open_state_reg, open_state_next;
    logic        a_open_reg, relay_reg, irq_reg;

    // a request still standing in its ack cycle is not taken twice:
    // the master only drops cyc/stb after it has seen ack, so the
    // slave masks the request with its own ack for that one cycle
    // bus decode
    wire         req      = wb_i.cyc & wb_i.stb & ~ack_reg;
    wire         wr       = req & wb_i.we;
    wire [31:0]  bmask    = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
    wire [31:0]  wdat     = wb_i.dat & bmask;
    wire         wr_ctrl  = wr & (wb_i.adr == `ADR_CTRL);
    wire         wr_class = wr & (wb_i.adr == `ADR_CLASS);
    wire         wr_acfg  = wr & (wb_i.adr == `ADR_A_CFG);
    wire         wr_bcfg  = wr & (wb_i.adr == `ADR_B_CFG);
    wire         wr_qual  = wr & (wb_i.adr == `ADR_QUAL);
    wire         wr_stat  = wr & (wb_i.adr == `ADR_STATUS);
    wire         wr_mask  = wr & (wb_i.adr == `ADR_MASK);

    // configuration fields
    wire         b_on     = ctrl_reg[`CTRL_B_ON];
    wire [2:0]   self_ack = {ctrl_reg[`CTRL_B_SELF], ctrl_reg[`CTRL_B_SELF], ctrl_reg[`CTRL_A_SELF]};
    wire [9:0]   trip_lvl = acfg_reg[9:0];
    wire [16:0]  a_dly    = 17'(acfg_reg[25:16] * `TICKS_PER_S);
    wire [3:0]   att_lim  = bcfg_reg[3:0];
    wire [8:0]   open_lim = bcfg_reg[24:16];
    wire [5:0]   a_qual   = qual_reg[5:0];
    wire [5:0]   b_qual   = qual_reg[13:8];
    wire         fb       = fb_sync_reg[1];

    // monitoring qualifier: always, not locked, or selected flag
    function automatic logic qual_ok(input logic [5:0] q, input logic lock, input logic [31:0] fl);
        logic [5:0] idx;
        idx = q - `QUAL_FLAG0;
        if (q == `QUAL_ALWAYS)
            qual_ok = 1'b1; // R06
        else if (q == `QUAL_LOCK)
            qual_ok = ~lock; // R07
        else
            qual_ok = (idx < 6'h20) ? fl[idx[4:0]] : 1'b0; // R08
    endfunction

    wire         a_en     = qual_ok(a_qual, lock_mon_i, logic_flag_n_i);
    wire         b_en     = b_on & qual_ok(b_qual, lock_mon_i, logic_flag_n_i); // R09

    // breaker a unload supervision
    wire         pow_high = power_pct_i >= trip_lvl;
    wire         a_run    = a_unload_i & pow_high;
    wire         a_exp    = a_run & (a_tmr_reg >= a_dly);
    wire         a_open_n = a_unload_i & (~pow_high | a_exp); // R01 R02

    // each rising edge of the close command while b_en is high is one attempt; the counter
    // saturates at MAX_ATTEMPT (ten) so it can never wrap to 0
    // and hide a failure from the limit compare
    // breaker b closing attempts
    wire         close_rise = close_cmd_i & ~close_d_reg;
    wire         closed_long = closed_tmr_reg >= CLOSED_TICKS;
    wire [3:0]   att_next = closed_long ? 4'h0 // R12
                          : (close_rise & b_en & att_cnt_reg < `MAX_ATTEMPT) ? att_cnt_reg + 4'h1 // R10
                          : att_cnt_reg;

    // alarms and status fire on the rising edge of a condition, so a
    // condition that stays true after an acknowledge does not re-arm;
    // a set and a clear in the same cycle leave the bit set
    // fault conditions and alarm latches
    wire [2:0]   cond;
    assign cond[0] = a_en & a_exp; // R02
    assign cond[1] = b_en & (att_cnt_reg >= att_lim) & fb; // R11 R13
    assign cond[2] = b_en & (open_state_reg == OPEN_FAIL); // R14
    wire [2:0]   set      = cond & ~cond_d_reg;
    wire         sw_ack   = wr_ctrl & wdat[`CTRL_ACK];
    wire         ack_all  = sw_ack | ack_sync_reg[1];
    wire [2:0]   clr      = {3{ack_all}} | (self_ack & ~cond); // R04 R05
    wire [2:0]   alarm_next = set | (alarm_reg & ~clr);
    wire [2:0]   status_next = set | (status_reg & ~(wr_stat ? wdat[2:0] : 3'h0));

    // open monitoring state machine
    always_comb begin
        open_state_next = open_state_reg;
        case (open_state_reg)
            OPEN_IDLE: begin
                if (open_seq_i & b_en & ~fb)
                    open_state_next = OPEN_RUN; // R14
            end
            OPEN_RUN: begin
                if (~open_seq_i | ~b_en | fb)
                    open_state_next = OPEN_IDLE; // R17
                else if (open_tmr_reg >= open_lim)
                    open_state_next = OPEN_FAIL; // R14
            end
            OPEN_FAIL: begin
                if (fb | ~b_en)
                    open_state_next = OPEN_IDLE;
            end
            default: open_state_next = OPEN_IDLE;
        endcase
    end

    // read data selection
    wire [31:0]  rd_mux =
        (wb_i.adr == `ADR_CTRL)   ? ctrl_reg :
        (wb_i.adr == `ADR_CLASS)  ? class_reg :
        (wb_i.adr == `ADR_A_CFG)  ? acfg_reg :
        (wb_i.adr == `ADR_B_CFG)  ? bcfg_reg :
        (wb_i.adr == `ADR_QUAL)   ? qual_reg :
        (wb_i.adr == `ADR_STATUS) ? {29'h0, status_reg} :
        (wb_i.adr == `ADR_MASK)   ? {29'h0, mask_reg} :
        (wb_i.adr == `ADR_STATE)  ? {18'h0, open_state_reg, 4'h0, att_cnt_reg, 1'b0, alarm_reg} :
        32'h0;

    // bus slave: ack one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg  <= req;
            rdat_reg <= req ? rd_mux : 32'h0;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg  <= `CTRL_RST;
            class_reg <= `CLASS_RST;
            acfg_reg  <= `A_CFG_RST;
            bcfg_reg  <= `B_CFG_RST;
            qual_reg  <= `QUAL_RST;
            mask_reg  <= 3'h0;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= ((ctrl_reg & ~bmask) | wdat) & `CTRL_MASK;
            if (wr_class)
                class_reg <= ((class_reg & ~bmask) | wdat) & `CLASS_MASK; // R03
            if (wr_acfg)
                acfg_reg <= ((acfg_reg & ~bmask) | wdat) & `A_CFG_MASK;
            if (wr_bcfg)
                bcfg_reg <= ((bcfg_reg & ~bmask) | wdat) & `B_CFG_MASK;
            if (wr_qual)
                qual_reg <= ((qual_reg & ~bmask) | wdat) & `QUAL_MASK;
            if (wr_mask)
                mask_reg <= wdat[2:0];
        end
    end

    // feedback contact and external acknowledge come from pins; only
    // the second flop of each pair is read by the logic
    // input synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fb_sync_reg  <= 2'b00;
            ack_sync_reg <= 2'b00;
        end else begin
            fb_sync_reg  <= {fb_sync_reg[0], breaker_b_feedback_i};
            ack_sync_reg <= {ack_sync_reg[0], ext_ack_i};
        end
    end

    // ten millisecond tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 17'h0;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg     <= (tick_cnt_reg == TICK_LAST); // R17
            tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 17'h0 : tick_cnt_reg + 17'h1;
        end
    end

    // every timer clears as soon as its start condition goes away; the
    // unload and closed timers hold at their end value, the open timer is
    // cleared once the state leaves OPEN_RUN; the unload timer is not gated by the
    // qualifier, so a fault held through a lock fires once it is lifted
    // second based timers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_tmr_reg      <= 17'h0;
            closed_tmr_reg <= 10'h0;
            open_tmr_reg   <= 9'h0;
        end else begin
            if (~a_run)
                a_tmr_reg <= 17'h0; // R17
            else if (tick_reg & ~a_exp)
                a_tmr_reg <= a_tmr_reg + 17'h1; // R02
            if (fb)
                closed_tmr_reg <= 10'h0; // R17
            else if (tick_reg & ~closed_long)
                closed_tmr_reg <= closed_tmr_reg + 10'h1; // R12
            if (open_state_reg != OPEN_RUN)
                open_tmr_reg <= 9'h0; // R17
            else if (tick_reg)
                open_tmr_reg <= open_tmr_reg + 9'h1; // R14
        end
    end

    // attempt counter, alarms and state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            att_cnt_reg    <= 4'h0;
            close_d_reg    <= 1'b0;
            open_state_reg <= OPEN_IDLE;
            cond_d_reg     <= 3'h0;
            alarm_reg      <= 3'h0;
            status_reg     <= 3'h0;
        end else begin
            att_cnt_reg    <= att_next;
            close_d_reg    <= close_cmd_i;
            open_state_reg <= open_state_next;
            cond_d_reg     <= cond;
            alarm_reg      <= alarm_next; // R04 R05 R11 R15
            status_reg     <= status_next;
        end
    end

    // registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_open_reg <= 1'b0;
            relay_reg  <= 1'b0;
            irq_reg    <= 1'b0;
        end else begin
            a_open_reg <= a_open_n; // R01
            relay_reg  <= close_cmd_i;
            irq_reg    <= |(status_next & mask_reg);
        end
    end

    assign wb_o.ack                = ack_reg;
    assign wb_o.dat                = rdat_reg;
    assign breaker_a_open_o        = a_open_reg;
    assign breaker_b_close_relay_o = relay_reg;
    assign a_unload_mismatch_msg_o = alarm_reg[0];
    assign b_close_failure_msg_o   = alarm_reg[1];
    assign b_open_failure_msg_o    = alarm_reg[2];
    assign a_class_o               = alarm_class_e'(class_reg[2:0]); // R03
    assign b_class_o               = alarm_class_e'(class_reg[6:4]); // R16
    assign irq_o                   = irq_reg;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_one_cycle_a: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack held longer than one cycle");
    trip_command_a: assert property (a_unload_i && !pow_high |=> breaker_a_open_o) // R01
        else $error("breaker a not opened below trip level");
    mismatch_alarm_a: assert property ($rose(cond[0]) |=> a_unload_mismatch_msg_o) // R02
        else $error("unload mismatch alarm missing");
    latch_hold_a: assert property (alarm_reg[0] && !self_ack[0] && !ack_all |=> alarm_reg[0]) // R04
        else $error("latched alarm dropped without acknowledge");
    ack_clears_a: assert property (ack_all && !set[1] |=> !b_close_failure_msg_o) // R05
        else $error("acknowledge did not clear alarm");
    lock_gate_a: assert property (a_qual == `QUAL_LOCK && lock_mon_i |-> !cond[0]) // R07
        else $error("fault evaluated while locked");
    flag_gate_a: assert property (b_qual == `QUAL_FLAG0 && !logic_flag_n_i[0] |-> cond[2:1] == 2'b00) // R08
        else $error("fault evaluated with flag false");
    b_off_a: assert property (!b_on |=> !$rose(alarm_reg[1]) && !$rose(alarm_reg[2])) // R09
        else $error("breaker b alarm raised while off");
    counter_clear_a: assert property (closed_long |=> att_cnt_reg == 4'h0) // R12
        else $error("attempt counter not cleared");
    open_fail_a: assert property (open_state_reg == OPEN_RUN && open_tmr_reg >= open_lim && open_seq_i
                                  && b_en && !fb |=> ##1 b_open_failure_msg_o) // R14 R15
        else $error("open failure not raised");
    tick_period_a: assert property (tick_reg |=> !tick_reg) // R17
        else $error("tick longer than one cycle");

    // bus slave handshake
    read_zero_a: assert property (!wb_o.ack |-> wb_o.dat == 32'h0)
        else $error("read data outside ack");
    ack_idle_a: assert property (!(wb_i.cyc && wb_i.stb) |=> !wb_o.ack)
        else $error("ack without request");

    // status and interrupt
    irq_level_a: assert property (irq_o == |(status_reg & $past(mask_reg)))
        else $error("interrupt level wrong");
    status_sticky_a: assert property (status_reg[0] && !wr_stat |=> status_reg[0])
        else $error("status bit lost");
    set_wins_a: assert property (set[1] |=> status_reg[1] && alarm_reg[1]) // R11
        else $error("set lost to clear");

    // unload supervision
    trip_release_a: assert property (a_unload_i && pow_high && !a_exp |=> !breaker_a_open_o) // R01
        else $error("breaker a opened above trip level");
    delay_restart_a: assert property (!a_run |=> a_tmr_reg == 17'h0) // R17
        else $error("unload timer not restarted");
    self_clear_a: assert property (alarm_reg[0] && self_ack[0] && !cond[0] |=> !a_unload_mismatch_msg_o) // R04
        else $error("self acknowledge did not clear");

    // breaker b supervision
    attempt_cap_a: assert property (att_cnt_reg <= `MAX_ATTEMPT) // R10
        else $error("attempt counter past ceiling");
    attempt_step_a: assert property (close_rise && b_en && !closed_long && att_cnt_reg < `MAX_ATTEMPT
                                     |=> att_cnt_reg == $past(att_cnt_reg) + 4'h1) // R10
        else $error("attempt not counted");
    relay_copy_a: assert property (close_cmd_i |=> breaker_b_close_relay_o) // R10
        else $error("close relay not driven");
    close_fail_a: assert property ($rose(cond[1]) |=> b_close_failure_msg_o) // R11
        else $error("close failure not raised");
    open_off_a: assert property (!b_en |=> open_state_reg == OPEN_IDLE) // R09
        else $error("open monitor active while off");
    open_restart_a: assert property (open_state_reg != OPEN_RUN |=> open_tmr_reg == 9'h0) // R17
        else $error("open timer not restarted");

    mismatch_seen_c: cover property ($rose(a_unload_mismatch_msg_o));
    close_fail_c: cover property ($rose(b_close_failure_msg_o));
    open_fail_c: cover property ($rose(b_open_failure_msg_o));
    irq_seen_c: cover property ($rose(irq_o));
    counter_clear_c: cover property (closed_long && att_cnt_reg != 4'h0);
endmodule

/* File: breaker_b_model.sv */
// behavioural breaker b: close relay in, feedback contact out, prompt or slow, may refuse to move
`timescale 1ns/1ps
module breaker_b_model (
    // clock
    input  wire logic clk_i,
    // commands from the supervision block and sequence
    input  wire logic close_relay_i,
    input  wire logic open_seq_i,
    // faults and speed ordered by the bench
    input  wire logic refuse_close_i,
    input  wire logic refuse_open_i,
    input  wire logic slow_i,
    // feedback contact, high while the breaker is open
    output logic      feedback_o
);
    logic relay_q  = 1'b0;
    int   wait_cnt = 0;
    initial feedback_o = 1'b1;
    // contact moves a while after a close pulse or during an open sequence
    always @(posedge clk_i) begin
        relay_q <= close_relay_i;
        if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 1) begin
            wait_cnt   <= 0;
            feedback_o <= ~feedback_o;
        end else if (close_relay_i && !relay_q && feedback_o && !refuse_close_i) begin
            wait_cnt <= slow_i ? 40 : 2;
        end else if (open_seq_i && !feedback_o && !refuse_open_i) begin
            wait_cnt <= slow_i ? 40 : 2;
        end
    end
endmodule

/* File: tb_breaker_supervision_monitor.sv */
// self-checking bench for the breaker supervision monitor
`timescale 1ns/1ps
`include "breaker_defs.svh"
module tb_breaker_supervision_monitor;
    import breaker_pkg::*;
    localparam int TC  = 10;
    localparam int SEC = TC * `TICKS_PER_S;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    wb_req_s      req   = '0;
    wb_rsp_s      rsp;
    logic [9:0]   power = 10'h0;
    logic         a_unload = 1'b0, a_open, close_cmd = 1'b0, open_seq = 1'b0, feedback, relay;
    logic         lock_mon = 1'b0, ext_ack = 1'b0, mm, cf, of, irq;
    logic         refuse_close = 1'b0, refuse_open = 1'b0, slow = 1'b0;
    logic [31:0]  flags = 32'h0, q;
    alarm_class_e ac, bc;
    int           bad_count = 0, num_checks = 0, cyc_count = 0;
    logic [7:0]   radr [6] = '{`ADR_CTRL, `ADR_CLASS, `ADR_A_CFG, `ADR_B_CFG, `ADR_QUAL, 8'h20};
    logic [31:0]  rval [6] = '{`CTRL_RST, `CLASS_RST, `A_CFG_RST, `B_CFG_RST, `QUAL_RST, 32'h0};

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    breaker_supervision_monitor #(.TICK_CYCLES(TC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp), .power_pct_i(power),
        .a_unload_i(a_unload), .breaker_a_open_o(a_open), .close_cmd_i(close_cmd),
        .open_seq_i(open_seq), .breaker_b_feedback_i(feedback), .breaker_b_close_relay_o(relay),
        .lock_mon_i(lock_mon), .logic_flag_n_i(flags), .ext_ack_i(ext_ack),
        .a_unload_mismatch_msg_o(mm), .b_close_failure_msg_o(cf), .b_open_failure_msg_o(of),
        .a_class_o(ac), .b_class_o(bc), .irq_o(irq));

    breaker_b_model i_model (
        .clk_i(clk_i), .close_relay_i(relay), .open_seq_i(open_seq), .refuse_close_i(refuse_close),
        .refuse_open_i(refuse_open), .slow_i(slow), .feedback_o(feedback));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        @(posedge clk_i);
        while (rsp.ack !== 1'b1) begin
            @(posedge clk_i);
        end
        chk(rsp.ack, 1'b1);
        q = rsp.dat;
        req <= '0;
        @(posedge clk_i);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // mismatch flag just before and just after the one second delay
    task automatic mm_delay(input logic exp);
        cycles(SEC - 30);
        chk(mm, 1'b0);
        cycles(60);
        chk(mm, exp);
    endtask

    task automatic ack_all();
        power <= 10'd20;
        bus(1'b1, `ADR_CTRL, 32'h9);
        cycles(4);
    endtask

    task automatic pulse_close();
        close_cmd <= 1'b1;
        @(posedge clk_i);
        close_cmd <= 1'b0;
        cycles(8);
    endtask

    // hang guard
    always @(posedge clk_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 40000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        cycles(12);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(ac, CLASS_B);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, radr[i], 32'h0);
            chk(q, rval[i]);
        end
        $display("test reset_values done");
        bus(1'b1, `ADR_A_CFG, 32'h0001_001e);
        bus(1'b1, `ADR_MASK, 32'h7);
        a_unload <= 1'b1;
        power    <= 10'd29;
        cycles(3);
        chk(a_open, 1'b1);
        power <= 10'd30;
        cycles(3);
        chk(a_open, 1'b0);
        power <= 10'd500;
        cycles(SEC / 2);
        power <= 10'd20;
        cycles(3);
        power <= 10'd500;
        mm_delay(1'b1);
        chk(a_open, 1'b1);
        chk(irq, 1'b1);
        bus(1'b0, `ADR_STATUS, 32'h0);
        chk(q, 32'h1);
        power <= 10'd20;
        cycles(5);
        chk(mm, 1'b1);
        ext_ack <= 1'b1;
        cycles(6);
        ext_ack <= 1'b0;
        chk(mm, 1'b0);
        bus(1'b1, `ADR_STATUS, 32'h1);
        cycles(3);
        chk(irq, 1'b0);
        bus(1'b1, `ADR_CTRL, 32'h3);
        power <= 10'd500;
        mm_delay(1'b1);
        power <= 10'd20;
        cycles(6);
        chk(mm, 1'b0);
        bus(1'b1, `ADR_CTRL, 32'h1);
        $display("test unload_mismatch done");
        bus(1'b1, `ADR_QUAL, 32'h1);
        lock_mon <= 1'b1;
        power    <= 10'd500;
        mm_delay(1'b0);
        lock_mon <= 1'b0;
        chk(mm, 1'b0);
        cycles(5);
        chk(mm, 1'b1);
        ack_all();
        chk(mm, 1'b0);
        bus(1'b1, `ADR_QUAL, 32'h7);
        power <= 10'd500;
        mm_delay(1'b0);
        flags <= 32'h20;
        chk(mm, 1'b0);
        cycles(5);
        chk(mm, 1'b1);
        ack_all();
        bus(1'b1, `ADR_QUAL, 32'h0);
        for (int k = 0; k < 7; k++) begin
            bus(1'b1, `ADR_CLASS, {25'h0, 3'(k % 6), 1'b0, 3'(k)});
            cycles(2);
            chk(ac, k);
            chk(bc, k % 6);
        end
        $display("test qualifiers_classes done");
        bus(1'b1, `ADR_B_CFG, 32'h000a_0002);
        bus(1'b1, `ADR_STATUS, 32'h7);
        refuse_close <= 1'b1;
        pulse_close();
        chk(cf, 1'b0);
        pulse_close();
        chk(cf, 1'b1);
        chk(irq, 1'b1);
        bus(1'b1, `ADR_MASK, 32'h5);
        cycles(3);
        chk(irq, 1'b0);
        bus(1'b1, `ADR_MASK, 32'h7);
        bus(1'b1, `ADR_STATUS, 32'h2);
        cycles(3);
        chk(irq, 1'b0);
        ack_all();
        refuse_close <= 1'b0;
        pulse_close();
        cycles(5 * SEC - 150);
        bus(1'b0, `ADR_STATE, 32'h0);
        chk(32'(q[7:4] == 4'h0), 32'h0);
        cycles(200);
        bus(1'b0, `ADR_STATE, 32'h0);
        chk(q[7:4], 4'h0);
        $display("test close_failure done");
        bus(1'b1, `ADR_CLASS, 32'h56);
        refuse_open <= 1'b1;
        open_seq    <= 1'b1;
        cycles(80);
        chk(of, 1'b0);
        cycles(50);
        chk(of, 1'b1);
        chk(bc, CLASS_F);
        bus(1'b1, `ADR_CTRL, 32'h8);
        cycles(150);
        chk(of, 1'b0);
        refuse_open <= 1'b0;
        slow        <= 1'b1;
        bus(1'b1, `ADR_CTRL, 32'h1);
        cycles(150);
        chk(of, 1'b0);
        chk(feedback, 1'b1);
        $display("test open_failure done");
        give_verdict();
    end
endmodule
